/* File: sim/ifel_core_model.sv */
// Core side model: takes each request as it starts and counts it.
// Assumes level requests on the same clock as the block.
`timescale 1ns/1ps
module ifel_core_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Requests from the block
    input wire logic irq_high,
    input wire logic irq_low,
    // Requests taken so far
    output logic [7:0] high_seen_q,
    output logic [7:0] low_seen_q
);
    logic high_q;  // Last high request level
    logic low_q;   // Last low request level
    // Count rising request levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {high_q, low_q, high_seen_q, low_seen_q} <= '0;
        end else begin
            high_q <= irq_high;
            low_q <= irq_low;
            high_seen_q <= high_seen_q + 8'(irq_high & ~high_q);
            low_seen_q <= low_seen_q + 8'(irq_low & ~low_q);
        end
    end
endmodule

/* File: sim/ifel_monitor.sv */
// Port checker for the interrupt flag block: bus handshakes and request gating.
// Assumes one clock and a synchronous active-low reset; bound to the top module.
`timescale 1ns/1ps
module ifel_monitor
    import ifel_pkg::*;
(
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Write channels
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Requests
    input wire logic irq_high,
    input wire logic irq_low
);
    // Both write channels taken at one edge
    wire wr_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
    // Read address taken
    wire rd_go = s_axi_arvalid & s_axi_arready;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Low byte written to the control register
    sequence s_ctl_wr;
        wr_go && s_axi_awaddr == IFEL_OFS_CONTROL && s_axi_wstrb[0];
    endsequence
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped early");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped early");
    property p_wresp;
        wr_go && s_axi_awaddr[1:0] == 2'h0 |=> s_axi_bvalid && s_axi_bresp == IFEL_RESP_OKAY;
    endproperty
    a_wresp: assert property (p_wresp) else $error("write answer late or wrong");
    property p_rack;
        rd_go |=> s_axi_rvalid;
    endproperty
    a_rack: assert property (p_rack) else $error("read answer late");
    property p_rerr;
        rd_go && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == IFEL_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_rerr: assert property (p_rerr) else $error("unmapped read not refused");
    property p_refuse;
        (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready);
    endproperty
    a_refuse: assert property (p_refuse) else $error("request taken while answer pending");
    property p_freeze;
        !ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready;
    endproperty
    a_freeze: assert property (p_freeze) else $error("request taken while frozen");
    property p_gate_off;
        (s_ctl_wr ##0 !s_axi_wdata[7]) ##1 ce |=> !irq_high;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("high request not blocked");
    property p_low_off;
        (s_ctl_wr ##0 !s_axi_wdata[6]) ##1 ce |=> !irq_low;
    endproperty
    a_low_off: assert property (p_low_off) else $error("low request not blocked");
    property p_core_req;
        (s_ctl_wr ##0 s_axi_wdata[7:0] == 8'hA4) ##1 ce |=> irq_high;
    endproperty
    a_core_req: assert property (p_core_req) else $error("timer request missing");
endmodule

bind ifel_top ifel_monitor mon_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq_high(irq_high), .irq_low(irq_low));

/* File: sim/interrupt_flag_enable_logic_tb.sv */
// Self-checking bench: register bus tasks, event pulses, request checks.
// Assumes the design timing of one-cycle bus answers and registered requests.
`timescale 1ns/1ps
module interrupt_flag_enable_logic_tb
    import ifel_pkg::*;
;
    logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, external_edge_pin, irq_high, irq_low;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr, port_upper_pins;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [7:0] high_seen, low_seen;
    ifel_evt_t events;
    ifel_enc_cfg_t enc_cfg;
    int n_errors, total_checks, i;
    // Event table: strobe, encoder setting, expected flags three
    logic [8:0] ev [9] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h002, 9'h010, 9'h008, 9'h004, 9'h004};
    logic [1:0] cf [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h3};
    logic [7:0] ex [9] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h08, 8'h04, 8'h02, 8'h00};
    ifel_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .port_upper_pins(port_upper_pins), .external_edge_pin(external_edge_pin),
        .events(events), .enc_cfg(enc_cfg), .irq_high(irq_high), .irq_low(irq_low));
    ifel_core_model core_u (.aclk(aclk), .aresetn(aresetn), .irq_high(irq_high), .irq_low(irq_low),
        .high_seen_q(high_seen), .low_seen_q(low_seen));
    // Free-running clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic tally_and_finish;
        if (n_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // A wait that ran out ends the run
    task automatic tmo(input logic ok);
        if (!ok) begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        logic awp, wp, aw_ok, w_ok, got;
        int k;
        {awp, wp, got} = 3'b110;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (k = 0; k < 50 && (awp || wp); k++) begin
            @(negedge aclk);
            aw_ok = awp & s_axi_awready;
            w_ok = wp & s_axi_wready;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
            {awp, wp} = {awp & ~aw_ok, wp & ~w_ok};
        end
        for (k = 0; k < 50 && !got; k++) begin
            @(negedge aclk);
            {got, resp} = {s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
        end
        s_axi_bready <= 1'b0;
        tmo(got);
    endtask
    task automatic axi_rd(input logic [3:0] a);
        logic got;
        int k;
        got = 1'b0;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        for (k = 0; k < 50 && !got; k++) begin
            @(negedge aclk);
            got = s_axi_arready;
            @(posedge aclk);
        end
        s_axi_arvalid <= 1'b0;
        tmo(got);
        got = 1'b0;
        for (k = 0; k < 50 && !got; k++) begin
            @(negedge aclk);
            {got, rd, resp} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
        end
        s_axi_rready <= 1'b0;
        tmo(got);
    endtask
    task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
        axi_rd(a);
        chk(n, rd, e);
    endtask
    task automatic pulse(input logic [8:0] e);
        @(posedge aclk);
        events <= e;
        @(posedge aclk);
        events <= '0;
        repeat (2) @(posedge aclk);
    endtask
    // Control write, then requests sampled once settled
    task automatic ctl_irq(input logic [7:0] c, input logic h, input logic l);
        axi_wr(IFEL_OFS_CONTROL, {24'h0, c}, 4'hF);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk("irq_high", irq_high, h);
        chk("irq_low", irq_low, l);
    endtask
    initial begin
        {aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'b0100000;
        {s_axi_awaddr, s_axi_wstrb, s_axi_araddr, port_upper_pins, external_edge_pin} = '0;
        {s_axi_wdata, events, enc_cfg, n_errors, total_checks} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 4; i++) rchk("reset value", 4'(4 * i), 32'h0);
        axi_rd(4'h2);
        chk("unmapped read", rd, 32'h0);
        chk("unmapped rresp", resp, IFEL_RESP_SLVERR);
        axi_wr(4'h6, 32'hFF, 4'hF);
        chk("unmapped write", resp, IFEL_RESP_SLVERR);
        pulse(9'h001);
        rchk("timer zero flag", IFEL_OFS_CONTROL, 32'h04);
        external_edge_pin <= 1'b1;
        port_upper_pins <= 4'h8;
        repeat (5) @(posedge aclk);
        rchk("edge and port flags", IFEL_OFS_CONTROL, 32'h07);
        ctl_irq(8'h00, 1'b0, 1'b0);
        ctl_irq(8'hA4, 1'b1, 1'b0);
        ctl_irq(8'h24, 1'b0, 1'b0);
        ctl_irq(8'h89, 1'b1, 1'b0);
        ctl_irq(8'h81, 1'b0, 1'b0);
        for (i = 0; i < 9; i++) begin
            enc_cfg <= cf[i];
            pulse(ev[i]);
            rchk("flags three", IFEL_OFS_FLAGS3, {24'h0, ex[i]});
            axi_wr(IFEL_OFS_FLAGS3, 32'h0, 4'hF);
        end
        enc_cfg <= 2'h0;
        pulse(9'h100);
        axi_wr(IFEL_OFS_PEN3, 32'h10, 4'hF);
        ctl_irq(8'h80, 1'b0, 1'b0);
        ctl_irq(8'hC0, 1'b1, 1'b0);
        ctl_irq(8'h40, 1'b0, 1'b0);
        axi_wr(IFEL_OFS_PRI, 32'h110, 4'hF);
        axi_wr(IFEL_OFS_PEN3, 32'h18, 4'hF);
        axi_wr(IFEL_OFS_FLAGS3, 32'h18, 4'hF);
        ctl_irq(8'h80, 1'b1, 1'b0);
        ctl_irq(8'h40, 1'b0, 1'b1);
        ctl_irq(8'h00, 1'b0, 1'b0);
        chk("low requests taken", low_seen, 8'h02);
        chk("high requests taken", high_seen, 8'h04);
        axi_wr(IFEL_OFS_PRI, 32'h0, 4'hF);
        axi_wr(IFEL_OFS_FLAGS3, 32'h0, 4'hF);
        enc_cfg <= 2'h2;
        axi_wr(IFEL_OFS_PEN3, 32'h04, 4'hF);
        ctl_irq(8'hC0, 1'b0, 1'b0);
        pulse(9'h008);
        @(negedge aclk);
        chk("position request", irq_high, 1'b1);
        ce <= 1'b0;
        repeat (3) @(posedge aclk);
        ce <= 1'b1;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("second reset", IFEL_OFS_FLAGS3, 32'h0);
        rchk("second reset control", IFEL_OFS_CONTROL, 32'h0);
        tally_and_finish();
    end
endmodule

/* File: src/ifel_pin_sync.sv */
// Two-stage synchroniser for a bus of pin inputs, with edge-change detection.
// Assumes asynchronous pins and one clock domain.
`timescale 1ns/1ps
module ifel_pin_sync
    import ifel_pkg::*;
#(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Pins and result
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync,
    output logic [WIDTH-1:0] pin_rise,
    output logic [WIDTH-1:0] pin_change
);
    logic [WIDTH-1:0] s1_q;    // First stage, read only by second
    logic [WIDTH-1:0] s2_q;    // Second stage
    logic [WIDTH-1:0] s3_q;    // Previous value for edges
    logic primed_q;            // Blocks false change right after reset

    logic [1:0] fill_q;  // Real pin values in chain

    // Synchroniser chain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            primed_q <= 1'b0;
            fill_q <= 2'h0;
        end else if (ce) begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            fill_q <= {fill_q[0], 1'b1};
            primed_q <= fill_q[1];
        end
    end

    assign pin_sync = s2_q;
    assign pin_rise = s2_q & ~s3_q & {WIDTH{primed_q}};
    assign pin_change = (s2_q ^ s3_q) & {WIDTH{primed_q}};
endmodule

/* File: src/ifel_pkg.sv */
// Package for the interrupt flag and enable block: register map, bit positions, resets, carriers.
// Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
package ifel_pkg;
    // Register byte offsets
    localparam logic [3:0] IFEL_OFS_CONTROL = 4'h0;  // Core control register
    localparam logic [3:0] IFEL_OFS_FLAGS3 = 4'h4;   // Peripheral flag register three
    localparam logic [3:0] IFEL_OFS_PEN3 = 4'h8;     // Peripheral enable register three
    localparam logic [3:0] IFEL_OFS_PRI = 4'hC;      // Priority mode and per-source priority
    // Control register bit positions
    localparam int IFEL_BIT_GHE = 7;   // Global / high enable
    localparam int IFEL_BIT_PLE = 6;   // Peripheral / low enable
    localparam int IFEL_BIT_T0E = 5;   // Timer zero overflow enable
    localparam int IFEL_BIT_EXE = 4;   // External edge enable
    localparam int IFEL_BIT_PCE = 3;   // Port change enable
    localparam int IFEL_BIT_T0F = 2;   // Timer zero overflow flag
    localparam int IFEL_BIT_EXF = 1;   // External edge flag
    localparam int IFEL_BIT_PCF = 0;   // Port change flag
    // Flag register three bit positions
    localparam int IFEL_BIT_PWF = 4;   // PWM time base flag
    localparam int IFEL_BIT_C3F = 3;   // Capture three / direction
    localparam int IFEL_BIT_C2F = 2;   // Capture two / position
    localparam int IFEL_BIT_C1F = 1;   // Capture one / velocity
    localparam int IFEL_BIT_T5F = 0;   // Timer five match flag
    // Priority register bit of the mode
    localparam int IFEL_BIT_PMODE = 8;
    // Reset values
    localparam logic [7:0] IFEL_RST_CONTROL = 8'h00;
    localparam logic [7:0] IFEL_RST_FLAGS3 = 8'h00;
    localparam logic [7:0] IFEL_RST_PEN3 = 8'h00;
    localparam logic [8:0] IFEL_RST_PRI = 9'h000;
    localparam logic [7:0] IFEL_MASK_FLAGS3 = 8'h1F;  // Implemented flag bits
    localparam logic [1:0] IFEL_RESP_OKAY = 2'h0;
    localparam logic [1:0] IFEL_RESP_SLVERR = 2'h2;
    localparam int IFEL_PIN_SYNC = 2;  // Pin synchroniser depth

    // Encoder configuration carrier
    typedef struct packed {
        logic encoder_on;            // Encoder mode replaces capture use
        logic velocity_disable_bit;  // 0 means velocity measurement on
    } ifel_enc_cfg_t;

    // Event strobes from peripherals (one-cycle pulses, same clock)
    typedef struct packed {
        logic pwm_match;      // PWM time base matched period, after postscaler
        logic capture_input_three_edge;      // Capture three active edge
        logic cap2_edge;      // Capture two active edge
        logic cap1_edge;      // Capture one active edge
        logic dir_change;     // Encoder direction changed
        logic pos_reset;      // Position counter reset by rollover or index
        logic vel_edge;       // Velocity capture edge
        logic t5_match;       // Timer five matched period
        logic t0_overflow;    // Timer zero overflow
    } ifel_evt_t;
endpackage

/* File: src/ifel_top.sv */
// Interrupt flag and enable logic with an AXI4-Lite register slave.
// Assumes event strobes are one-cycle pulses on aclk; pins are asynchronous.
//
// How it works
// RULE_01 - Flags set on events regardless of enables
// RULE_02 - Software clears flag before enabling source
// RULE_03 - Priority off: global bit gates all requests
// RULE_04 - Priority on: top bit gates high priority
// RULE_05 - Priority off: peripheral bit gates peripheral requests
// RULE_06 - Priority on: peripheral bit gates low priority
// RULE_07 - Timer zero overflow sets sticky flag
// RULE_08 - External edge sets sticky flag
// RULE_09 - Upper port pin change sets sticky flag
// RULE_10 - Port change enable gates change request
// RULE_11 - PWM period match sets its flag
// RULE_12 - Capture edge sets channel flag
// RULE_13 - Encoder on: direction change sets channel three
// RULE_14 - Encoder on: position reset sets channel two
// RULE_15 - Encoder velocity edge sets channel one
// RULE_16 - Timer five period match sets flag
// RULE_17 - Position counter reset raises request
// RULE_18 - Flag, enable and gates make request
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ifel_top
    import ifel_pkg::*;
(
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Asynchronous pins: upper port pins and external edge
    input wire logic [3:0] port_upper_pins,
    input wire logic external_edge_pin,
    // Peripheral events and encoder configuration
    input wire ifel_evt_t events,
    input wire ifel_enc_cfg_t enc_cfg,
    // Requests to the core
    output logic irq_high,
    output logic irq_low
);
    // Register state
    logic [7:0] ctrl_q;        // Enables in 7:3, flags in 2:0
    logic [7:0] flags3_q;      // Peripheral flags three
    logic [7:0] pen3_q;        // Peripheral enables three
    logic [8:0] pri_q;         // Bit 8 priority mode; 7:0 high-priority select per flags3 bit
    logic [7:0] ctrl_d;
    logic [7:0] flags3_d;
    // Bus handshake state
    // Taken early
    logic aw_held_q;
    logic w_held_q;
    // Early copies
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    // Write answer
    logic bvalid_q;
    logic [1:0] bresp_q;
    // Read answer
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    // Core requests
    logic irq_high_q;
    logic irq_low_q;

    // Pin synchroniser: bit 4 external edge, 3:0 port pins
    logic [4:0] pin_rise;
    logic [4:0] pin_change;
    ifel_pin_sync #(
        .WIDTH(5)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .pin_in({external_edge_pin, port_upper_pins}),
        .pin_sync(),
        .pin_rise(pin_rise),
        .pin_change(pin_change)
    );

    // Write channel decode
    // Refused while busy
    wire aw_ok = s_axi_awvalid & ~aw_held_q & ~bvalid_q;
    wire w_ok = s_axi_wvalid & ~w_held_q & ~bvalid_q;
    // Both halves in
    wire have_aw = aw_held_q | aw_ok;
    wire have_w = w_held_q | w_ok;
    wire wr_go = have_aw & have_w & ~bvalid_q;
    // Early copy first
    wire [3:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
    wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
    // Lane 0 bits, 1 mode
    wire wr_lane0 = wr_go & wr_strb[0];
    wire wr_lane1 = wr_go & wr_strb[1];
    // Register selects
    wire wr_ctrl = wr_lane0 & (wr_addr == IFEL_OFS_CONTROL);
    wire wr_flags3 = wr_lane0 & (wr_addr == IFEL_OFS_FLAGS3);
    wire wr_pen3 = wr_lane0 & (wr_addr == IFEL_OFS_PEN3);
    wire wr_pri = wr_go & (wr_addr == IFEL_OFS_PRI);
    // Others get an error
    wire wr_mapped = (wr_addr == IFEL_OFS_CONTROL) | (wr_addr == IFEL_OFS_FLAGS3) |
                     (wr_addr == IFEL_OFS_PEN3) | (wr_addr == IFEL_OFS_PRI);

    // Read channel decode
    // Refused while busy
    wire rd_go = s_axi_arvalid & ~rvalid_q;
    // Unmapped: error
    wire rd_mapped = (s_axi_araddr == IFEL_OFS_CONTROL) | (s_axi_araddr == IFEL_OFS_FLAGS3) |
                     (s_axi_araddr == IFEL_OFS_PEN3) | (s_axi_araddr == IFEL_OFS_PRI);
    // Upper bits read 0
    wire [31:0] rd_mux = (s_axi_araddr == IFEL_OFS_CONTROL) ? {24'h000000, ctrl_q} :
                         (s_axi_araddr == IFEL_OFS_FLAGS3) ? {24'h000000, flags3_q} :
                         (s_axi_araddr == IFEL_OFS_PEN3) ? {24'h000000, pen3_q} :
                         (s_axi_araddr == IFEL_OFS_PRI) ? {23'h000000, pri_q} : 32'h00000000;

    // Event sources into flags
    wire ev_t0 = events.t0_overflow;                                     // RULE_07
    wire ev_ext = pin_rise[4];                                           // RULE_08
    wire ev_port = |pin_change[3:0];                                     // RULE_09
    wire ev_pwm = events.pwm_match;                                      // RULE_11
    wire ev_c3 = enc_cfg.encoder_on ? events.dir_change : events.capture_input_three_edge;  // RULE_12 RULE_13
    wire ev_c2 = enc_cfg.encoder_on ? events.pos_reset : events.cap2_edge;   // RULE_12 RULE_14 RULE_17
    // Velocity gated
    wire ev_c1 = enc_cfg.encoder_on ? (events.vel_edge & ~enc_cfg.velocity_disable_bit)
                                    : events.cap1_edge;                  // RULE_12 RULE_15
    wire ev_t5 = events.t5_match;                                        // RULE_16
    // Flag positions
    wire [2:0] core_ev = {ev_t0, ev_ext, ev_port};
    wire [7:0] p3_ev = {3'b000, ev_pwm, ev_c3, ev_c2, ev_c1, ev_t5};

    // Next flag values: data write, then event set wins over any clear
    always_comb begin
        // Hold by default
        ctrl_d = ctrl_q;
        flags3_d = flags3_q;
        // Write replaces byte
        if (wr_ctrl) begin
            ctrl_d = wr_data[7:0];
        end
        // Unused bits stay 0
        if (wr_flags3) begin
            flags3_d = wr_data[7:0] & IFEL_MASK_FLAGS3;
        end
        // Set wins over clear
        ctrl_d[2:0] = ctrl_d[2:0] | core_ev;                // RULE_01
        flags3_d = flags3_d | (p3_ev & IFEL_MASK_FLAGS3);   // RULE_01
    end

    // Request gating
    wire prio_on = pri_q[IFEL_BIT_PMODE];
    // Top control bits
    wire g_hi = ctrl_q[IFEL_BIT_GHE];
    wire g_lo = ctrl_q[IFEL_BIT_PLE];
    wire t0_act = ctrl_q[IFEL_BIT_T0F] & ctrl_q[IFEL_BIT_T0E];  // RULE_18
    wire ex_act = ctrl_q[IFEL_BIT_EXF] & ctrl_q[IFEL_BIT_EXE];  // RULE_18
    wire pc_act = ctrl_q[IFEL_BIT_PCF] & ctrl_q[IFEL_BIT_PCE];  // RULE_10
    // Any core source
    wire core_act = t0_act | ex_act | pc_act;
    wire [7:0] p3_act = flags3_q & pen3_q;                      // RULE_18
    // Priority split
    wire p3_hi = |(p3_act & pri_q[7:0]);
    wire p3_lo = |(p3_act & ~pri_q[7:0]);
    // Priority off: one request line, global and peripheral gates
    wire req_flat = g_hi & (core_act | (g_lo & (|p3_act)));   // RULE_03 RULE_05
    // Priority on: core sources are high; peripherals by their select bit
    wire req_hi = g_hi & (core_act | p3_hi);                  // RULE_04
    wire req_lo = g_lo & p3_lo;                               // RULE_06
    // Low line in mode only
    wire irq_high_d = prio_on ? req_hi : req_flat;
    wire irq_low_d = prio_on & req_lo;

    // Register file and request outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= IFEL_RST_CONTROL;
            flags3_q <= IFEL_RST_FLAGS3;
            pen3_q <= IFEL_RST_PEN3;
            pri_q <= IFEL_RST_PRI;
            irq_high_q <= 1'b0;
            irq_low_q <= 1'b0;
        end else if (ce) begin
            // Flags, requests
            ctrl_q <= ctrl_d;
            flags3_q <= flags3_d;
            irq_high_q <= irq_high_d;
            irq_low_q <= irq_low_d;
            // Enables three
            if (wr_pen3) begin
                pen3_q <= wr_data[7:0] & IFEL_MASK_FLAGS3;
            end
            // Lane 0 select, 1 mode
            if (wr_pri) begin
                if (wr_strb[0]) begin
                    pri_q[7:0] <= wr_data[7:0] & IFEL_MASK_FLAGS3;
                end
                if (wr_lane1) begin
                    pri_q[IFEL_BIT_PMODE] <= wr_data[IFEL_BIT_PMODE];
                end
            end
        end
    end

    // Write address and data holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (ce) begin
            if (wr_go) begin
                // Copies released
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end else begin
                // Lone channel kept
                if (aw_ok) begin
                    aw_held_q <= 1'b1;
                    awaddr_q <= s_axi_awaddr;
                end
                if (w_ok) begin
                    w_held_q <= 1'b1;
                    wdata_q <= s_axi_wdata;
                    wstrb_q <= s_axi_wstrb;
                end
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= IFEL_RESP_OKAY;
        end else if (ce) begin
            // Both halves in
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_mapped ? IFEL_RESP_OKAY : IFEL_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= IFEL_RESP_OKAY;
        end else if (ce) begin
            // Caught at address
            if (rd_go) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_mapped ? IFEL_RESP_OKAY : IFEL_RESP_SLVERR;
            end else if (s_axi_rready) begin
                // Answer taken
                rvalid_q <= 1'b0;
            end
        end
    end

    // Ready signals are combinational accept terms
    // Low while frozen
    assign s_axi_awready = aw_ok & ce;
    assign s_axi_wready = w_ok & ce;
    assign s_axi_arready = rd_go & ce;
    // From flops
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    // Request flops
    assign irq_high = irq_high_q;
    assign irq_low = irq_low_q;
endmodule
